// ===== hdl/rdp_pkg.sv
// Shared constants and types for the G/H receive DDR output port.
// Assumes one system clock domain; words arrive already decoded upstream.
package rdp_pkg;
    localparam int WORD_W = 10;
    localparam int BYTE_W = 8;
    localparam int OUT_W = 10;
    // Output bit positions
    localparam int KFLAG_BIT = 8;
    localparam int BIT9_POS = 9;
    localparam int G_KFLAG_NIB_BIT = 3;
    localparam int H_LOW_BIT = 5;
    localparam int HALF_W = 5;
    // Reset and substitution values
    localparam logic [OUT_W-1:0] OUT_RST = 10'h000;
    localparam logic [OUT_W-1:0] ALL_ONES = 10'h3ff;
    localparam logic [BYTE_W-1:0] BYTE_ONES = 8'hff;
    // Layout select encodings
    localparam logic LAYOUT_MUX = 1'b0;
    localparam logic LAYOUT_NIBBLE = 1'b1;

    typedef enum logic [0:0] {
        RDP_PH_FALL = 1'b0,
        RDP_PH_RISE = 1'b1
    } rdp_phase_e;

    typedef struct packed {
        logic [WORD_W-1:0] raw;
        logic [BYTE_W-1:0] data;
        logic kflag;
        logic err;
    } rdp_word_s;

    localparam rdp_word_s WORD_RST = '{raw: 10'h000, data: 8'h00, kflag: 1'b0, err: 1'b0};
endpackage : rdp_pkg

// ===== hdl/rdp_rx_ddr_gh.sv
// Receive DDR output port for channel pair G/H.
// Assumes received words come from logic on i_clk; receive clock and mode pins are asynchronous.
// Operation
// - Launch data on both receive-clock edges
// - Multiplexed layout: H on rising, G falling
// - Nibble layout: low nibble falling, high rising
// - Nibble layout: H on bits 9:5, G low
// - Nibble coded: bit 3 is G K-flag rising
// - Multiplexed raw: ninth, tenth bits on 8, 9
// - Multiplexed coded: bit 8 flags K-character byte
// - Nibble raw: bits 8, 9 carry H halves
// - Nibble coded: bit 8 H data bit 3, then K-flag
// - Coding enable selects decoded byte plus K-flag
// - Layout select: 0 multiplexed, 1 nibble
// - Error substitution forces errored words to ones, only with coding enabled
`timescale 1ns/1ps
module rdp_rx_ddr_gh (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_rx_clk,
    input wire logic i_coding_enable,
    input wire logic i_interface_layout_select,
    input wire logic i_error_substitute_enable,
    input wire logic i_word_valid,
    input wire rdp_pkg::rdp_word_s i_word_g,
    input wire rdp_pkg::rdp_word_s i_word_h,
    output logic [7:0] o_rx_data_pair_gh,
    output logic o_rx_bit8_kflag_gh,
    output logic o_rx_bit9_gh
);
    // Replace an errored word by all ones when substitution is armed
    function automatic rdp_pkg::rdp_word_s subst(input rdp_pkg::rdp_word_s w, input logic arm);
        rdp_pkg::rdp_word_s r;
        r = w;
        if (arm && w.err) begin
            r.raw = rdp_pkg::ALL_ONES;
            r.data = rdp_pkg::BYTE_ONES;
            r.kflag = 1'b1;
        end
        return r;
    endfunction : subst

    // Synchronisers: receive clock and mode pins
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic rclk_d;
    rdp_pkg::rdp_word_s pend_g;
    rdp_pkg::rdp_word_s pend_h;
    rdp_pkg::rdp_word_s act_g;
    rdp_pkg::rdp_word_s act_h;
    rdp_pkg::rdp_phase_e phase;
    logic [rdp_pkg::OUT_W-1:0] out_bus;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            rclk_d <= 1'b0;
        end else if (i_ce) begin
            sync1 <= {i_error_substitute_enable, i_interface_layout_select, i_coding_enable, i_rx_clk};
            sync2 <= sync1;
            rclk_d <= sync2[0];
        end
    end

    wire rclk_s = sync2[0];
    wire code_en = sync2[1];
    wire layout = sync2[2];
    wire arm = sync2[3] & sync2[1];
    wire rise = rclk_s & ~rclk_d;
    wire fall = ~rclk_s & rclk_d;
    wire launch = i_ce & (rise | fall);

    // Falling phase draws from the pending pair, rising phase from the active pair
    wire rdp_pkg::rdp_word_s sel_g = subst(fall ? pend_g : act_g, arm);
    wire rdp_pkg::rdp_word_s sel_h = subst(fall ? pend_h : act_h, arm);

    // Fill bits that carry no data with ones for a substituted word
    wire fill_g = arm & sel_g.err;
    wire fill_h = arm & sel_h.err;

    // Multiplexed layout
    wire rdp_pkg::rdp_word_s mux_w = rise ? sel_h : sel_g;
    wire [rdp_pkg::OUT_W-1:0] mux_raw = mux_w.raw;
    wire fill_mux = arm & mux_w.err;
    wire [rdp_pkg::OUT_W-1:0] mux_cod = {fill_mux, mux_w.kflag, mux_w.data};
    wire [rdp_pkg::OUT_W-1:0] mux_out = code_en ? mux_cod : mux_raw;

    // Nibble layout
    wire [rdp_pkg::OUT_W-1:0] nib_raw = rise ? {sel_h.raw[9:5], sel_g.raw[9:5]}
                                             : {sel_h.raw[4:0], sel_g.raw[4:0]};
    wire [rdp_pkg::OUT_W-1:0] nib_cod = rise
        ? {sel_h.data[7], sel_h.kflag, sel_h.data[6:4], sel_g.data[7], sel_g.kflag, sel_g.data[6:4]}
        : {fill_h, sel_h.data[3:0], fill_g, sel_g.data[3:0]};
    wire [rdp_pkg::OUT_W-1:0] nib_out = code_en ? nib_cod : nib_raw;

    wire [rdp_pkg::OUT_W-1:0] next_out = (layout == rdp_pkg::LAYOUT_NIBBLE) ? nib_out : mux_out;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pend_g <= rdp_pkg::WORD_RST;
            pend_h <= rdp_pkg::WORD_RST;
        end else if (i_ce && i_word_valid) begin
            pend_g <= i_word_g;
            pend_h <= i_word_h;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            act_g <= rdp_pkg::WORD_RST;
            act_h <= rdp_pkg::WORD_RST;
        end else if (i_ce && fall) begin
            act_g <= pend_g;
            act_h <= pend_h;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            out_bus <= rdp_pkg::OUT_RST;
            phase <= rdp_pkg::RDP_PH_FALL;
        end else if (launch) begin
            out_bus <= next_out;
            phase <= rise ? rdp_pkg::RDP_PH_RISE : rdp_pkg::RDP_PH_FALL;
        end
    end

    assign o_rx_data_pair_gh = out_bus[7:0];
    assign o_rx_bit8_kflag_gh = out_bus[rdp_pkg::KFLAG_BIT];
    assign o_rx_bit9_gh = out_bus[rdp_pkg::BIT9_POS];

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    wire is_mux = layout == rdp_pkg::LAYOUT_MUX;
    wire is_nib = layout == rdp_pkg::LAYOUT_NIBBLE;

    sequence s_launch;
        i_ce && (rise || fall);
    endsequence
    sequence s_idle;
        !(i_ce && (rise || fall));
    endsequence
    sequence s_fall_launch;
        i_ce && fall;
    endsequence
    sequence s_rise_launch;
        i_ce && rise;
    endsequence

    a_edge_phase: assert property (s_launch |=> phase == ($past(rise) ? rdp_pkg::RDP_PH_RISE : rdp_pkg::RDP_PH_FALL))
        else $error("phase does not follow receive clock edge");

    a_hold_between: assert property (s_idle |=> $stable(out_bus))
        else $error("output changed without a receive clock edge");

    a_ce_freeze: assert property (!i_ce
        |=> $stable(out_bus) && $stable(sync2) && $stable(act_g) && $stable(pend_g))
        else $error("state moved while clock enable low");

    a_pend_load: assert property (i_ce && i_word_valid
        |=> pend_g == $past(i_word_g) && pend_h == $past(i_word_h))
        else $error("pending pair not loaded from input words");

    a_act_copy: assert property (s_fall_launch |=> act_g == $past(pend_g) && act_h == $past(pend_h))
        else $error("active pair not copied on falling phase");

    a_act_hold: assert property (s_rise_launch |=> $stable(act_g) && $stable(act_h))
        else $error("active pair changed on rising phase");

    a_mux_rise_h: assert property (s_launch and (rise && is_mux && !code_en && !act_h.err) |=> out_bus == $past(act_h.raw))
        else $error("multiplexed rising phase is not channel H word");

    a_mux_fall_g: assert property (s_launch and (fall && is_mux && !code_en && !pend_g.err) |=> out_bus == $past(pend_g.raw))
        else $error("multiplexed falling phase is not channel G word");

    a_mux_kflag: assert property (s_launch and (rise && is_mux && code_en && !act_h.err)
        |=> out_bus[8:0] == {$past(act_h.kflag), $past(act_h.data)})
        else $error("multiplexed coded K-flag or byte wrong");

    a_mux_fall_kflag: assert property (s_fall_launch and (is_mux && code_en && !pend_g.err)
        |=> out_bus[8:0] == {$past(pend_g.kflag), $past(pend_g.data)})
        else $error("multiplexed coded falling phase wrong");

    a_mux_cod_b9: assert property (s_launch and (is_mux && code_en && !arm) |=> !out_bus[9])
        else $error("bit 9 not low in multiplexed coded layout");

    a_nib_low_first: assert property (s_launch and (fall && is_nib && !code_en && !arm)
        |=> out_bus == {$past(pend_h.raw[4:0]), $past(pend_g.raw[4:0])})
        else $error("nibble falling phase is not low halves");

    a_nib_high_next: assert property (s_launch and (rise && is_nib && !code_en && !arm)
        |=> out_bus[9:5] == $past(act_h.raw[9:5]))
        else $error("nibble rising phase is not high half of H");

    a_nib_g_high: assert property (s_rise_launch and (is_nib && !code_en && !arm)
        |=> out_bus[4:0] == $past(act_g.raw[9:5]))
        else $error("nibble rising phase is not high half of G");

    a_nib_cod_low: assert property (s_fall_launch and (is_nib && code_en && !arm)
        |=> out_bus == {1'b0, $past(pend_h.data[3:0]), 1'b0, $past(pend_g.data[3:0])})
        else $error("coded nibble falling phase wrong");

    a_nib_gk_flag: assert property (s_launch and (rise && is_nib && code_en && !act_g.err)
        |=> out_bus[rdp_pkg::G_KFLAG_NIB_BIT] == $past(act_g.kflag))
        else $error("bit 3 is not G K-flag on rising phase");

    a_nib_hk_bit8: assert property (s_launch and (is_nib && code_en && !arm)
        |=> out_bus[8] == ($past(rise) ? $past(act_h.kflag) : $past(pend_h.data[3])))
        else $error("bit 8 wrong in coded nibble layout");

    a_err_ones: assert property (s_launch and (fall && is_mux && arm && pend_g.err) |=> out_bus == rdp_pkg::ALL_ONES)
        else $error("errored word not replaced by ones");

    a_mux_rise_err: assert property (s_rise_launch and (is_mux && arm && act_h.err) |=> out_bus == rdp_pkg::ALL_ONES)
        else $error("errored H word not replaced by ones");

    a_nib_err_g: assert property (s_fall_launch and (is_nib && arm && pend_g.err) |=> out_bus[4:0] == 5'h1f)
        else $error("errored G nibble not replaced by ones");

    a_nib_err_h: assert property (s_rise_launch and (is_nib && arm && act_h.err) |=> out_bus[9:5] == 5'h1f)
        else $error("errored H nibble not replaced by ones");
endmodule : rdp_rx_ddr_gh

// ===== tb/rdp_mac_model.sv
// Protocol-device model: makes the free-running receive clock, captures both phases.
// Assumes the port output settles within 40 ns of each receive-clock edge.
`timescale 1ns/1ps
module rdp_mac_model (
    output logic o_rx_clk,
    input wire logic [9:0] i_bus,
    output logic [9:0] o_fall,
    output logic [9:0] o_rise
);
    initial begin
        o_rx_clk = 1'b1;
        o_fall = 10'h000;
        o_rise = 10'h000;
    end
    always #80 o_rx_clk = ~o_rx_clk;
    always @(negedge o_rx_clk) begin
        #40 o_fall = i_bus;
    end
    always @(posedge o_rx_clk) begin
        #40 o_rise = i_bus;
    end
endmodule : rdp_mac_model

// ===== tb/tb.sv
// Self-checking bench for the G/H receive DDR port.
// Assumes the design package and the protocol-device model are compiled first.
`timescale 1ns/1ps
module tb;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic lay = 1'b0, cod = 1'b0, sub = 1'b0, vld = 1'b0, ce = 1'b1;
    rdp_pkg::rdp_word_s wg = rdp_pkg::WORD_RST, wh = rdp_pkg::WORD_RST, eg, eh;
    logic [7:0] d;
    logic b8, b9, rxc;
    logic [9:0] cf, cr;
    logic [15:0] lf = 16'h0033;
    int fails = 0, cmp_count = 0;
    always #5 i_clk = ~i_clk;
    rdp_rx_ddr_gh u_rdp_rx_ddr_gh (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce), .i_rx_clk(rxc),
        .i_coding_enable(cod), .i_interface_layout_select(lay), .i_error_substitute_enable(sub),
        .i_word_valid(vld), .i_word_g(wg), .i_word_h(wh), .o_rx_data_pair_gh(d),
        .o_rx_bit8_kflag_gh(b8), .o_rx_bit9_gh(b9));
    rdp_mac_model u_rdp_mac_model (.o_rx_clk(rxc), .i_bus({b9, b8, d}), .o_fall(cf), .o_rise(cr));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic rnd(output rdp_pkg::rdp_word_s w);
        lf = lfsr(lf);
        w[15:0] = lf;
        lf = lfsr(lf);
        w[19:16] = lf[3:0];
    endtask : rnd
    // Errored word seen as all ones when substitution and coding are on
    function automatic rdp_pkg::rdp_word_s fix(input rdp_pkg::rdp_word_s w);
        if (sub && cod && w.err)
            return '{raw: 10'h3ff, data: 8'hff, kflag: 1'b1, err: 1'b1};
        w.err = 1'b0;
        return w;
    endfunction : fix
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: bus %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        if (fails == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    initial begin
        #100000;
        fails++;
        print_verdict();
    end
    initial begin
        repeat (8) @(negedge i_clk);
        i_nrst = 1'b1;
        for (int m = 0; m < 32; m++) begin
            @(posedge rxc);
            @(negedge i_clk);
            lay = m[0];
            cod = m[1];
            sub = m[2];
            rnd(wg);
            rnd(wh);
            vld = 1'b1;
            @(negedge i_clk);
            vld = 1'b0;
            if (m[4]) begin
                ce = 1'b0;
                repeat (3) @(negedge i_clk);
                ce = 1'b1;
            end
            @(posedge rxc);
            #50;
            eg = fix(wg);
            eh = fix(wh);
            if (!lay && !cod) begin
                check(cf, eg.raw);
                check(cr, eh.raw);
            end else if (!lay) begin
                check(cf, {eg.err, eg.kflag, eg.data});
                check(cr, {eh.err, eh.kflag, eh.data});
            end else if (!cod) begin
                check(cf, {eh.raw[4:0], eg.raw[4:0]});
                check(cr, {eh.raw[9:5], eg.raw[9:5]});
            end else begin
                check(cf, {eh.err, eh.data[3:0], eg.err, eg.data[3:0]});
                check(cr, {eh.data[7], eh.kflag, eh.data[6:4], eg.data[7], eg.kflag, eg.data[6:4]});
            end
        end
        print_verdict();
    end
endmodule : tb
